/* src/dtr_pkg.sv */
/*
 * Shared definitions of the DAC load and indicator pin block: register indices,
 * field positions, reset values, timing counts and the bus, pair-setting and indicator-state types.
 * Assumes a 100 MHz system clock and a 32-bit Avalon-MM slave port with byte addresses.
 */
package dtr_pkg;

	// ----------------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int DAC_W = 12;
	localparam int NUM_DAC = 4;
	localparam int NUM_GPIO = 4;
	localparam int IRQ_W = 3;

	// ----------------------------------------------------------------------
	// Register indices; the byte address is four times the index.
	// ----------------------------------------------------------------------
	localparam logic [5:0] IDX_CTRL = 6'h00;
	localparam logic [5:0] IDX_STAGE0 = 6'h01;
	localparam logic [5:0] IDX_ACTIVE0 = 6'h05;
	localparam logic [5:0] IDX_GPIO_DRIVE = 6'h09;
	localparam logic [5:0] IDX_GPIO_LEVEL = 6'h0a;
	localparam logic [5:0] IDX_IRQ_STATUS = 6'h0b;
	localparam logic [5:0] IDX_IRQ_MASK = 6'h0c;
	localparam logic [5:0] IDX_ADC_PIN_CONFIG = 6'h11;

	// ----------------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------------
	localparam int CTRL_CLOSED_LOOP_BIT = 0;
	localparam int CTRL_RANGE12_LSB = 4;
	localparam int CTRL_CLAMP12_BIT = 6;
	localparam int CTRL_RANGE34_LSB = 8;
	localparam int CTRL_CLAMP34_BIT = 10;
	localparam logic [10:0] CTRL_MASK = 11'h771;
	localparam logic [10:0] CTRL_RESET = 11'h000;
	localparam int CFG_IND_ENABLE_BIT = 0;
	localparam int CFG_IND_SELECT_BIT = 1;
	localparam logic [7:0] ADC_PIN_CONFIG_RESET = 8'h00;
	localparam int IRQ_LOAD_BIT = 0;
	localparam int IRQ_CONV_BIT = 1;
	localparam int IRQ_GPIO_BIT = 2;

	// ----------------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int PULSE_TIME_US = 20;
	localparam int PULSE_CYCLES = PULSE_TIME_US * CLK_MHZ;
	localparam int PULSE_CNT_W = 11;

	// ----------------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------------
	typedef struct packed {
		logic read;
		logic write;
		logic [ADDR_W-1:0] address;
		logic [3:0] byteenable;
		logic [DATA_W-1:0] writedata;
	} dtr_avs_req_type;

	typedef struct packed {
		logic [1:0] range;
		logic clamp;
	} dtr_pair_setting_type;

	typedef enum logic {IND_IDLE, IND_PULSE} dtr_ind_state_type;

endpackage : dtr_pkg

/* src/dtr_pins.sv */
/*
 * DAC load strobe, conversion indicator pin, open-drain general I/O pins and
 * shared pair settings, with an Avalon-MM register slave and a level interrupt.
 * Assumes the ADC logic on clk_sys supplies a one-cycle end-of-sequence pulse
 * and a ready level, and that the pins carry external pull-ups.
 */
// The Avalon-MM register port was left to the implementer.
// Summary of operation
// RL1: While the load strobe is low, copy every staging code into its active register.
// RL2: Outputs follow only active registers; staging writes alone never move an output.
// RL3: Strobe acts only in open-loop mode; closed-loop operation ignores it.
// RL4: Indicator pin stays high impedance after reset until its enable bit is set.
// RL5: Conversion-done mode drives a 20 us low pulse at each finished sequence.
// RL6: Setting the select bit turns the indicator into the ADC-ready level.
// RL7: In ADC-ready mode the pin is high while the ADC is ready, else low.
// RL8: Outputs 1 and 2 share one range and clamp; outputs 3 and 4 another.
// RL9: Each general pin is open drain: pulled low or released, level readable.
// RL10: The load strobe passes a two-flop synchroniser before use.
module dtr_pins (
	input wire logic clk_sys,
	input wire logic arst_n,
	input dtr_pkg::dtr_avs_req_type avsRequest,
	output logic [dtr_pkg::DATA_W-1:0] avsReaddata,
	output logic avsWaitrequest,
	output logic irq,
	input wire logic dacLoadStrobeN,
	input wire logic convSequenceDone,
	input wire logic adcReady,
	output logic [dtr_pkg::NUM_DAC-1:0][dtr_pkg::DAC_W-1:0] bipolarOut,
	output dtr_pkg::dtr_pair_setting_type pairSetting12,
	output dtr_pkg::dtr_pair_setting_type pairSetting34,
	output logic conversionIndicatorOut,
	output logic conversionIndicatorOe,
	input wire logic [dtr_pkg::NUM_GPIO-1:0] generalIoIn,
	output logic [dtr_pkg::NUM_GPIO-1:0] generalIoOut,
	output logic [dtr_pkg::NUM_GPIO-1:0] generalIoOe
);

	// ----------------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------------
	logic [dtr_pkg::NUM_GPIO:0] syncMeta;
	logic [dtr_pkg::NUM_GPIO:0] syncStable;
	logic [dtr_pkg::NUM_GPIO:0] syncLast;
	logic strobeLowSync;
	logic strobeFell;
	logic [dtr_pkg::NUM_GPIO-1:0] gpioLevel;
	logic gpioChanged;

	// Bit 0 carries the strobe and bits 4:1 the general pins; all reset to their idle high.
	// The strobe and the general pins come from outside; the first stage feeds only the second.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			syncMeta <= '1;
			syncStable <= '1;
			syncLast <= '1;
		end else begin
			syncMeta <= {generalIoIn, dacLoadStrobeN}; // [RL10]
			syncStable <= syncMeta; // [RL10]
			syncLast <= syncStable;
		end
	end

	// Synchronised levels and their edges.
	assign strobeLowSync = !syncStable[0];
	assign strobeFell = syncLast[0] && !syncStable[0];
	assign gpioLevel = syncStable[dtr_pkg::NUM_GPIO:1]; // [RL9]
	assign gpioChanged = (syncStable[dtr_pkg::NUM_GPIO:1] != syncLast[dtr_pkg::NUM_GPIO:1]);

	// ----------------------------------------------------------------------
	// Bus handshake
	// ----------------------------------------------------------------------
	logic busAck;
	logic next_busAck;
	logic [5:0] regIndex;
	logic accessWrite;
	logic [dtr_pkg::DATA_W-1:0] next_avsReaddata;

	// The request is accepted one edge after it appears; waitrequest falls for that one cycle.
	always_comb begin
		next_busAck = (avsRequest.read || avsRequest.write) && !busAck;
	end

	// Registers are word aligned; the two low address bits are ignored.
	assign regIndex = avsRequest.address[7:2];
	assign accessWrite = avsRequest.write && busAck;

	// Waitrequest is registered, so every access costs exactly one wait state.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			busAck <= 1'b0;
			avsWaitrequest <= 1'b1;
			avsReaddata <= '0;
		end else begin
			busAck <= next_busAck;
			avsWaitrequest <= !next_busAck;
			avsReaddata <= next_avsReaddata;
		end
	end

	// Merges the enabled byte lanes of a write into the old word.
	function automatic logic [31:0] mergeLanes(
		input logic [31:0] oldWord,
		input logic [31:0] newWord,
		input logic [3:0] laneEnable
	);
		logic [31:0] result;
		result = oldWord;
		for (int lane = 0; lane < 4; lane++) begin
			if (laneEnable[lane]) begin
				result[lane*8 +: 8] = newWord[lane*8 +: 8];
			end
		end
		return result;
	endfunction : mergeLanes

	// ----------------------------------------------------------------------
	// Registers and the DAC transfer
	// ----------------------------------------------------------------------
	logic [10:0] ctrlReg;
	logic [10:0] next_ctrlReg;
	logic [7:0] adcPinConfig;
	logic [7:0] next_adcPinConfig;
	logic [dtr_pkg::NUM_DAC-1:0][dtr_pkg::DAC_W-1:0] stageCode;
	logic [dtr_pkg::NUM_DAC-1:0][dtr_pkg::DAC_W-1:0] next_stageCode;
	logic [dtr_pkg::NUM_DAC-1:0][dtr_pkg::DAC_W-1:0] next_bipolarOut;
	logic [dtr_pkg::NUM_GPIO-1:0] gpioPullLow;
	logic [dtr_pkg::NUM_GPIO-1:0] next_gpioPullLow;
	logic [dtr_pkg::IRQ_W-1:0] irqStatus;
	logic [dtr_pkg::IRQ_W-1:0] next_irqStatus;
	logic [dtr_pkg::IRQ_W-1:0] irqMask;
	logic [dtr_pkg::IRQ_W-1:0] next_irqMask;
	logic [dtr_pkg::IRQ_W-1:0] irqEvents;
	logic openLoop;
	logic transferActive;
	logic [31:0] mergedWord;

	// The strobe moves the active codes only in open-loop operation.
	assign openLoop = !ctrlReg[dtr_pkg::CTRL_CLOSED_LOOP_BIT];
	assign transferActive = strobeLowSync && openLoop; // [RL3]

	// Writes, the strobe transfer and sticky interrupt flags; a set beats a clear.
	always_comb begin
		next_ctrlReg = ctrlReg;
		next_adcPinConfig = adcPinConfig;
		next_stageCode = stageCode;
		next_bipolarOut = bipolarOut;
		next_gpioPullLow = gpioPullLow;
		next_irqMask = irqMask;
		next_irqStatus = irqStatus;
		mergedWord = '0;
		if (accessWrite) begin
			unique case (regIndex)
				dtr_pkg::IDX_CTRL: begin
					mergedWord = mergeLanes({21'h000000, ctrlReg}, avsRequest.writedata,
						avsRequest.byteenable);
					next_ctrlReg = mergedWord[10:0] & dtr_pkg::CTRL_MASK;
				end
				dtr_pkg::IDX_GPIO_DRIVE: begin
					mergedWord = mergeLanes({28'h0000000, gpioPullLow}, avsRequest.writedata,
						avsRequest.byteenable);
					next_gpioPullLow = mergedWord[dtr_pkg::NUM_GPIO-1:0];
				end
				dtr_pkg::IDX_IRQ_STATUS: begin
					mergedWord = mergeLanes(32'h00000000, avsRequest.writedata,
						avsRequest.byteenable);
					next_irqStatus = irqStatus & ~mergedWord[dtr_pkg::IRQ_W-1:0];
				end
				dtr_pkg::IDX_IRQ_MASK: begin
					mergedWord = mergeLanes({29'h00000000, irqMask}, avsRequest.writedata,
						avsRequest.byteenable);
					next_irqMask = mergedWord[dtr_pkg::IRQ_W-1:0];
				end
				dtr_pkg::IDX_ADC_PIN_CONFIG: begin
					mergedWord = mergeLanes({24'h000000, adcPinConfig}, avsRequest.writedata,
						avsRequest.byteenable);
					next_adcPinConfig = mergedWord[7:0]; // [RL4] [RL6]
				end
				default: begin
					for (int i = 0; i < dtr_pkg::NUM_DAC; i++) begin
						if (regIndex == dtr_pkg::IDX_STAGE0 + 6'(i)) begin
							mergedWord = mergeLanes({20'h00000, stageCode[i]},
								avsRequest.writedata, avsRequest.byteenable);
							next_stageCode[i] = mergedWord[dtr_pkg::DAC_W-1:0]; // [RL2]
						end
					end
				end
			endcase
		end
		// Level-sensitive: the copy repeats every cycle while the strobe stays low.
		if (transferActive) begin
			for (int i = 0; i < dtr_pkg::NUM_DAC; i++) begin
				next_bipolarOut[i] = stageCode[i]; // [RL1] [RL2]
			end
		end
		next_irqStatus = next_irqStatus | irqEvents;
	end

	// Register state; the control and pin-config reset values come from the package, the rest reset to zero.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ctrlReg <= dtr_pkg::CTRL_RESET;
			adcPinConfig <= dtr_pkg::ADC_PIN_CONFIG_RESET;
			stageCode <= '0;
			bipolarOut <= '0;
			gpioPullLow <= '0;
			irqStatus <= '0;
			irqMask <= '0;
		end else begin
			ctrlReg <= next_ctrlReg;
			adcPinConfig <= next_adcPinConfig;
			stageCode <= next_stageCode;
			bipolarOut <= next_bipolarOut;
			gpioPullLow <= next_gpioPullLow;
			irqStatus <= next_irqStatus;
			irqMask <= next_irqMask;
		end
	end

	// ----------------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------------
	// Read data is captured on the edge that lowers waitrequest; unmapped words read zero.
	always_comb begin
		next_avsReaddata = avsReaddata;
		if (next_busAck && avsRequest.read) begin
			next_avsReaddata = '0;
			unique case (regIndex)
				dtr_pkg::IDX_CTRL: next_avsReaddata[10:0] = ctrlReg;
				dtr_pkg::IDX_GPIO_DRIVE: next_avsReaddata[dtr_pkg::NUM_GPIO-1:0] = gpioPullLow;
				dtr_pkg::IDX_GPIO_LEVEL: next_avsReaddata[dtr_pkg::NUM_GPIO-1:0] = gpioLevel;
				dtr_pkg::IDX_IRQ_STATUS: next_avsReaddata[dtr_pkg::IRQ_W-1:0] = irqStatus;
				dtr_pkg::IDX_IRQ_MASK: next_avsReaddata[dtr_pkg::IRQ_W-1:0] = irqMask;
				dtr_pkg::IDX_ADC_PIN_CONFIG: next_avsReaddata[7:0] = adcPinConfig;
				default: begin
					for (int i = 0; i < dtr_pkg::NUM_DAC; i++) begin
						if (regIndex == dtr_pkg::IDX_STAGE0 + 6'(i)) begin
							next_avsReaddata[dtr_pkg::DAC_W-1:0] = stageCode[i];
						end
						if (regIndex == dtr_pkg::IDX_ACTIVE0 + 6'(i)) begin
							next_avsReaddata[dtr_pkg::DAC_W-1:0] = bipolarOut[i];
						end
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------------
	// Conversion indicator pulse
	// ----------------------------------------------------------------------
	// Eleven counter bits cover the 2000 cycles of one pulse at 100 MHz.
	dtr_pkg::dtr_ind_state_type indState;
	dtr_pkg::dtr_ind_state_type next_indState;
	logic [dtr_pkg::PULSE_CNT_W-1:0] pulseCount;
	logic [dtr_pkg::PULSE_CNT_W-1:0] next_pulseCount;

	// A sequence ending mid-pulse restarts the full width so no end is swallowed.
	always_comb begin
		next_indState = indState;
		next_pulseCount = pulseCount;
		unique case (indState)
			dtr_pkg::IND_IDLE: begin
				if (convSequenceDone) begin
					next_indState = dtr_pkg::IND_PULSE;
					next_pulseCount = dtr_pkg::PULSE_CNT_W'(dtr_pkg::PULSE_CYCLES - 1); // [RL5]
				end
			end
			dtr_pkg::IND_PULSE: begin
				if (convSequenceDone) begin
					next_pulseCount = dtr_pkg::PULSE_CNT_W'(dtr_pkg::PULSE_CYCLES - 1); // [RL5]
				end else if (pulseCount == '0) begin
					next_indState = dtr_pkg::IND_IDLE;
				end else begin
					next_pulseCount = pulseCount - 1'b1;
				end
			end
		endcase
	end

	// Pulse state and its down-counter.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			indState <= dtr_pkg::IND_IDLE;
			pulseCount <= '0;
		end else begin
			indState <= next_indState;
			pulseCount <= next_pulseCount;
		end
	end

	// ----------------------------------------------------------------------
	// Pin drivers, pair settings and interrupt
	// ----------------------------------------------------------------------
	logic next_indOut;
	logic next_indOe;
	logic next_irq;
	dtr_pkg::dtr_pair_setting_type next_pair12;
	dtr_pkg::dtr_pair_setting_type next_pair34;

	// Events by their status positions; a strobe seen in closed loop raises nothing.
	always_comb begin
		irqEvents = '0;
		irqEvents[dtr_pkg::IRQ_LOAD_BIT] = strobeFell && openLoop; // [RL3]
		irqEvents[dtr_pkg::IRQ_CONV_BIT] = convSequenceDone;
		irqEvents[dtr_pkg::IRQ_GPIO_BIT] = gpioChanged;
	end

	// Indicator source, shared pair settings and the masked interrupt level.
	always_comb begin
		next_indOe = adcPinConfig[dtr_pkg::CFG_IND_ENABLE_BIT]; // [RL4]
		if (adcPinConfig[dtr_pkg::CFG_IND_SELECT_BIT]) begin
			next_indOut = adcReady; // [RL6] [RL7]
		end else begin
			next_indOut = (next_indState != dtr_pkg::IND_PULSE); // [RL5]
		end
		next_pair12.range = ctrlReg[dtr_pkg::CTRL_RANGE12_LSB +: 2]; // [RL8]
		next_pair12.clamp = ctrlReg[dtr_pkg::CTRL_CLAMP12_BIT]; // [RL8]
		next_pair34.range = ctrlReg[dtr_pkg::CTRL_RANGE34_LSB +: 2]; // [RL8]
		next_pair34.clamp = ctrlReg[dtr_pkg::CTRL_CLAMP34_BIT]; // [RL8]
		next_irq = |(next_irqStatus & irqMask);
	end

	// General pins are open drain: their data line is held low and only the enable moves.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			conversionIndicatorOut <= 1'b1;
			conversionIndicatorOe <= 1'b0;
			pairSetting12 <= '0;
			pairSetting34 <= '0;
			irq <= 1'b0;
			generalIoOut <= '0;
			generalIoOe <= '0;
		end else begin
			conversionIndicatorOut <= next_indOut;
			conversionIndicatorOe <= next_indOe;
			pairSetting12 <= next_pair12;
			pairSetting34 <= next_pair34;
			irq <= next_irq;
			generalIoOut <= '0; // [RL9]
			generalIoOe <= next_gpioPullLow; // [RL9]
		end
	end

endmodule : dtr_pins

/* verif/dtr_pins_props.sv */
/*
 * Port checks of dtr_pins, bound into every instance.
 * Assumes full-word register writes, as the bench issues them.
 */
module dtr_pins_props (
	input wire logic clk_sys,
	input wire logic arst_n,
	input dtr_pkg::dtr_avs_req_type avsRequest,
	input wire logic avsWaitrequest,
	input wire logic dacLoadStrobeN,
	input wire logic convSequenceDone,
	input wire logic adcReady,
	input wire logic [dtr_pkg::NUM_DAC-1:0][dtr_pkg::DAC_W-1:0] bipolarOut,
	input wire logic conversionIndicatorOut,
	input wire logic conversionIndicatorOe,
	input wire logic [dtr_pkg::NUM_GPIO-1:0] generalIoOut
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// Shadow state
	// ----
	localparam logic [7:0] ADDR_CTRL = {dtr_pkg::IDX_CTRL, 2'b00};
	localparam logic [7:0] ADDR_STAGE0 = {dtr_pkg::IDX_STAGE0, 2'b00};
	localparam logic [7:0] ADDR_CFG = {dtr_pkg::IDX_ADC_PIN_CONFIG, 2'b00};
	// Pulse age runs 0 to 1999 while the pin is low; it reads 2000 at the first high cycle.
	localparam logic [11:0] PULSE_LAST = 12'(dtr_pkg::PULSE_CYCLES - 1);
	localparam logic [11:0] PULSE_DONE = 12'(dtr_pkg::PULSE_CYCLES);
	logic [1:0] cfg, next_cfg;
	logic closedLoop, next_closedLoop, wrAcc;
	logic [11:0] stage0, next_stage0, sinceDone, next_sinceDone;
	assign wrAcc = avsRequest.write && !avsWaitrequest;
	// The pulse age is only kept in pulse mode, so a mode change never leaves a stale count.
	always_comb begin
		next_cfg = cfg;
		next_closedLoop = closedLoop;
		next_stage0 = stage0;
		if (wrAcc && avsRequest.address == ADDR_CFG) begin
			next_cfg = avsRequest.writedata[1:0];
		end
		if (wrAcc && avsRequest.address == ADDR_CTRL) begin
			next_closedLoop = avsRequest.writedata[0];
		end
		if (wrAcc && avsRequest.address == ADDR_STAGE0) begin
			next_stage0 = avsRequest.writedata[11:0];
		end
		next_sinceDone = (sinceDone == 12'hfff) ? sinceDone : sinceDone + 12'h1;
		if (convSequenceDone) next_sinceDone = 12'h0;
		if (cfg != 2'h1) next_sinceDone = 12'hfff;
	end
	// Shadow registers.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cfg <= 2'h0;
			closedLoop <= 1'b0;
			stage0 <= 12'h000;
			sinceDone <= 12'hfff;
		end else begin
			cfg <= next_cfg;
			closedLoop <= next_closedLoop;
			stage0 <= next_stage0;
			sinceDone <= next_sinceDone;
		end
	end
	// ----
	// Assertions
	// ----
	default clocking dcb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	AST_IND_HIZ: assert property (!cfg[0] |=> !conversionIndicatorOe)
		else $error("indicator driven while disabled");
	AST_PULSE_LOW: assert property (
		sinceDone <= PULSE_LAST |-> !conversionIndicatorOut)
		else $error("done pulse too short");
	AST_PULSE_END: assert property (
		sinceDone == PULSE_DONE |-> conversionIndicatorOut)
		else $error("done pulse too long");
	AST_READY_LEVEL: assert property (
		cfg == 2'h3 && $past(cfg) == 2'h3 |-> conversionIndicatorOut == $past(adcReady))
		else $error("ready level wrong");
	AST_CLOSED_HOLD: assert property (closedLoop |=> $stable(bipolarOut))
		else $error("output moved in closed loop");
	AST_IDLE_HOLD: assert property (dacLoadStrobeN[*3] |=> $stable(bipolarOut))
		else $error("output moved without strobe");
	AST_SYNC_DELAY: assert property (
		dacLoadStrobeN[*3] ##1 !dacLoadStrobeN |=> $stable(bipolarOut)[*2])
		else $error("strobe used before synchronised");
	AST_COPY_LOW: assert property (
		(!dacLoadStrobeN)[*4] ##0 !closedLoop |=> bipolarOut[0] == $past(stage0))
		else $error("staging code not copied");
	AST_OPEN_DRAIN: assert property (generalIoOut == 4'h0)
		else $error("general pin driven high");
	COV_COPY: cover property ((!dacLoadStrobeN)[*4] ##0 !closedLoop);
	COV_PULSE_END: cover property (sinceDone == PULSE_DONE);
	COV_READY: cover property (cfg == 2'h3 && adcReady);
endmodule : dtr_pins_props

bind dtr_pins dtr_pins_props chk (.clk_sys(clk_sys), .arst_n(arst_n), .avsRequest(avsRequest),
	.avsWaitrequest(avsWaitrequest), .dacLoadStrobeN(dacLoadStrobeN),
	.convSequenceDone(convSequenceDone), .adcReady(adcReady), .bipolarOut(bipolarOut),
	.conversionIndicatorOut(conversionIndicatorOut),
	.conversionIndicatorOe(conversionIndicatorOe), .generalIoOut(generalIoOut));

/* verif/dtr_host_model.sv */
/*
 * Host-side pin model: launches the load strobe, resolves the open-drain pins.
 * Assumes bench commands change just after rising edges of clk_sys.
 */
module dtr_host_model (
	input wire logic clk_sys,
	input wire logic strobeCmdN,
	input wire logic [3:0] extPull,
	input wire logic [3:0] ioOut,
	input wire logic [3:0] ioOe,
	input wire logic indOut,
	input wire logic indOe,
	output logic dacLoadStrobeN,
	output logic [3:0] ioIn,
	output logic indLevel
);
	timeunit 1ns;
	timeprecision 1ps;
	logic flip = 1'b0;
	// The strobe leaves a host flop, so it lags the command by one cycle.
	initial dacLoadStrobeN = 1'b1;
	always @(posedge clk_sys) begin
		dacLoadStrobeN <= strobeCmdN;
		flip <= ~flip;
	end
	// Pull-ups lift released pins; the device or an outside party pulls low.
	assign ioIn = ~((ioOe & ~ioOut) | extPull);
	// A floating indicator toggles, so a stale level never passes for driven.
	assign indLevel = indOe ? indOut : flip;
endmodule : dtr_host_model

/* verif/dtr_pins_test.sv */
/*
 * Self-checking bench of dtr_pins with the host pin model and a read scoreboard.
 * Assumes the register map and latencies of the designer's hand-over.
 */
module dtr_pins_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0, arst_n = 1'b0, strobeCmdN = 1'b1, convDone = 1'b0, adcReady = 1'b0;
	dtr_pkg::dtr_avs_req_type req = '0;
	logic [31:0] rdata, v, expQ[$];
	logic waitReq, irq, strobeN, indOut, indOe, indLevel;
	logic [3:0][11:0] bip;
	logic [11:0] code[4];
	dtr_pkg::dtr_pair_setting_type set12, set34;
	logic [3:0] ioIn, ioOut, ioOe, extPull = 4'h0;
	int n_errors = 0;
	int n_checks = 0;
	// 100 MHz clock.
	always #5 clk_sys = ~clk_sys;
	dtr_pins uut (.clk_sys(clk_sys), .arst_n(arst_n), .avsRequest(req), .avsReaddata(rdata),
		.avsWaitrequest(waitReq), .irq(irq), .dacLoadStrobeN(strobeN),
		.convSequenceDone(convDone), .adcReady(adcReady), .bipolarOut(bip),
		.pairSetting12(set12), .pairSetting34(set34), .conversionIndicatorOut(indOut),
		.conversionIndicatorOe(indOe), .generalIoIn(ioIn), .generalIoOut(ioOut),
		.generalIoOe(ioOe));
	dtr_host_model host (.clk_sys(clk_sys), .strobeCmdN(strobeCmdN), .extPull(extPull),
		.ioOut(ioOut), .ioOe(ioOe), .indOut(indOut), .indOe(indOe),
		.dacLoadStrobeN(strobeN), .ioIn(ioIn), .indLevel(indLevel));
	// ----
	// Tasks
	// ----
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// One bus access; an extra edge after release keeps back-to-back calls clean.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		req <= '{!wr, wr, a, 4'hf, d};
		do @(posedge clk_sys); while (waitReq);
		req <= '0;
		@(posedge clk_sys);
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		expQ.push_back(exp);
		bus(1'b0, a, 32'h0);
	endtask : rd
	task automatic strobe();
		strobeCmdN <= 1'b0;
		repeat (6) @(posedge clk_sys);
		strobeCmdN <= 1'b1;
		repeat (6) @(posedge clk_sys);
	endtask : strobe
	task automatic end_sim();
		if (n_errors == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : end_sim
	// Scoreboard: each answered read takes the oldest expectation.
	always @(posedge clk_sys) begin
		if (req.read && !waitReq) chk(rdata, expQ.pop_front());
	end
	// Watchdog: the run needs about 2100 cycles.
	initial begin
		#100us;
		n_errors++;
		end_sim();
	end
	// ----
	// Main sequence
	// ----
	initial begin
		v = $urandom(32'h68ac1d96);
		repeat (12) @(posedge clk_sys);
		arst_n <= 1'b1;
		@(posedge clk_sys);
		chk(indOe, 1'b0);
		rd(8'h44, 32'h0);
		rd(8'h80, 32'h0);
		bus(1'b1, 8'h2c, 32'h7);
		bus(1'b1, 8'h30, 32'h1);
		for (int i = 0; i < 4; i++) begin
			code[i] = 12'($urandom);
			bus(1'b1, 8'h04 + 8'(4 * i), {20'h0, code[i]});
			rd(8'h14 + 8'(4 * i), 32'h0);
		end
		strobe();
		for (int i = 0; i < 4; i++) chk(bip[i], code[i]);
		chk(irq, 1'b1);
		rd(8'h2c, 32'h1);
		bus(1'b1, 8'h2c, 32'h1);
		@(posedge clk_sys);
		chk(irq, 1'b0);
		// Closed loop must leave the active codes alone.
		bus(1'b1, 8'h00, 32'h1);
		bus(1'b1, 8'h04, {20'h0, ~code[0]});
		strobe();
		rd(8'h14, {20'h0, code[0]});
		rd(8'h2c, 32'h0);
		v = $urandom & 32'h770;
		bus(1'b1, 8'h00, v);
		@(posedge clk_sys);
		chk(set12, {v[5:4], v[6]});
		chk(set34, {v[9:8], v[10]});
		bus(1'b1, 8'h24, 32'h5);
		repeat (3) @(posedge clk_sys);
		rd(8'h28, 32'ha);
		extPull <= 4'h8;
		repeat (3) @(posedge clk_sys);
		rd(8'h28, 32'h2);
		// Done pulse, then the ready level.
		bus(1'b1, 8'h44, 32'h1);
		// The enable reaches the pin one edge after the register takes the write.
		@(posedge clk_sys);
		chk(indOe, 1'b1);
		convDone <= 1'b1;
		@(posedge clk_sys);
		convDone <= 1'b0;
		repeat (2) @(posedge clk_sys);
		chk(indLevel, 1'b0);
		repeat (1998) @(posedge clk_sys);
		chk(indLevel, 1'b0);
		@(posedge clk_sys);
		chk(indLevel, 1'b1);
		chk(irq, 1'b0);
		bus(1'b1, 8'h44, 32'h3);
		for (int i = 0; i < 8; i++) begin
			v[0] = 1'($urandom);
			adcReady <= v[0];
			repeat (2) @(posedge clk_sys);
			chk(indLevel, v[0]);
		end
		end_sim();
	end
endmodule : dtr_pins_test
